// ### seip_params.svh
`ifndef SEIP_PARAMS_SVH
`define SEIP_PARAMS_SVH

// Timing, printed units, and the cycle counts derived from the clock rate
`define SEIP_CLK_PERIOD_NS 10
`define SEIP_PULSE_US 100
`define SEIP_GAP_US 100
`define SEIP_REPEAT_MS 5
`define SEIP_PULSE_CYC (`SEIP_PULSE_US * 1000 / `SEIP_CLK_PERIOD_NS)
`define SEIP_GAP_CYC (`SEIP_GAP_US * 1000 / `SEIP_CLK_PERIOD_NS)
`define SEIP_REPEAT_CYC (`SEIP_REPEAT_MS * 1000000 / `SEIP_CLK_PERIOD_NS)

// Register offsets
`define SEIP_OFS_MASK 4'h0
`define SEIP_OFS_CTRL 4'h1
`define SEIP_OFS_WAKE_EN 4'h2
`define SEIP_OFS_STAT_BASE 4'h3
`define SEIP_OFS_STATE 4'hA

// Status group indices, in offset order from the status base
`define SEIP_G_SUPPLY 0
`define SEIP_G_THERMAL 1
`define SEIP_G_BUS 2
`define SEIP_G_HIGHSIDE 3
`define SEIP_G_DRAIN_SOURCE_OVERVOLT_REG 4
`define SEIP_G_DEVICE 5
`define SEIP_G_WAKE 6
`define SEIP_NUM_GROUPS 7
`define SEIP_NUM_MASKED 6

// Bits that may drive the masked group sources, and the brake bits checked on stop entry
`define SEIP_ALLOW_SUPPLY 8'hF0
`define SEIP_ALLOW_THERMAL 8'h7F
`define SEIP_ALLOW_ALL 8'hFF
`define SEIP_ALLOW_DEVICE 8'h03
`define SEIP_DRAIN_SOURCE_OVERVOLT_REG_BRAKE 8'hC0

// Control and wake bit positions
`define SEIP_CTRL_REPEAT 0
`define SEIP_CTRL_BRAKE 1
`define SEIP_WAKE_SRC_BITS 4
`define SEIP_WAKE_BRAKE 4
`define SEIP_WAKE_ALL 8'h1F

// Reset values
`define SEIP_RST_MASK 6'h3F
`define SEIP_RST_CTRL 2'h1
`define SEIP_RST_WAKE_EN 4'hF

`endif

// ### seip_pkg.sv
package seip_pkg;

   typedef enum logic [2:0] {
      SEIP_MODE_INIT = 3'b000,
      SEIP_MODE_NORMAL = 3'b001,
      SEIP_MODE_STOP = 3'b010,
      SEIP_MODE_SLEEP = 3'b011,
      SEIP_MODE_RESTART = 3'b100,
      SEIP_MODE_FAILSAFE = 3'b101
   } seip_mode_t;

   typedef enum logic [1:0] {
      SEIP_ST_IDLE = 2'b00,
      SEIP_ST_LOW = 2'b01,
      SEIP_ST_GAP = 2'b10
   } seip_state_t;

endpackage

// ### seip_pulser.sv
// What this block does
// - Drive pin low for pulse width, release
// - Keep pin high minimum gap between pulses
// - Pulses never change the operating mode
// - One mask register enables each group source
// - Group source is OR of allowed bits
// - Wake event interrupts only when source enabled
// - Wake sources: bus, pin, timers, brake
// - Masked and wake methods work together
// - Supply1, second shutdown, power-on never interrupt
// - Only serial and checksum flags repeat
// - No pin activity in restart, failsafe, sleep
// - Stop entry interrupts on uncleared wake bits
// - Readable status refreshed at pulse falling edge
// - Status bits latched until cleared by software
// - Uncleared status keeps producing repeat pulses
// - Repeat enable bit stops repeat pulses
// - Coincident or overlapping events give one pulse
// - Init mode samples pin for development mode
// - Repeat period nominally five milliseconds
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "seip_params.svh"

module seip_pulser #(
   parameter int PULSE_CYC = `SEIP_PULSE_CYC,
   parameter int GAP_CYC = `SEIP_GAP_CYC,
   parameter int REPEAT_CYC = `SEIP_REPEAT_CYC,
   parameter int CW = 20
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire seip_pkg::seip_mode_t mode_i,
   input wire logic [7:0] supply_set_i,
   input wire logic [7:0] thermal_set_i,
   input wire logic [7:0] bus_set_i,
   input wire logic [7:0] highside_set_i,
   input wire logic [7:0] drain_source_overvolt_reg_set_i,
   input wire logic [7:0] device_set_i,
   input wire logic [4:0] wake_set_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic irq_in_i,
   output logic irq_n_o,
   output logic irq_oe_o,
   output logic sdm_select_o
);

   localparam int NG = `SEIP_NUM_GROUPS;

   // OR of the bits of one group that may raise a source
   function automatic logic grp_any(input logic [7:0] bits,
                                    input logic [7:0] allow);
      grp_any = |(bits & allow);
   endfunction

   function automatic logic [CW-1:0] last_of(input int n);
      last_of = CW'(n - 1);
   endfunction

   seip_pkg::seip_state_t state;
   seip_pkg::seip_state_t next_state;
   seip_pkg::seip_mode_t mode_q;

   logic [7:0] set_vec [NG];
   logic [7:0] clr_vec [NG];
   logic [7:0] stat [NG];
   logic [7:0] view [NG];
   logic [7:0] next_stat [NG];
   logic [5:0] int_mask;
   logic [1:0] ctrl;
   logic [3:0] wake_en;
   logic [CW-1:0] tcnt;
   logic [CW-1:0] rcnt;
   logic pend;
   logic active;
   logic start;
   logic tdone;
   logic evt_masked;
   logic evt_wake;
   logic stop_entry;
   logic repeat_hit;
   logic trig;
   logic [7:0] wake_qual;
   logic [7:0] rd_mux;

   assign set_vec[`SEIP_G_SUPPLY] = supply_set_i;
   assign set_vec[`SEIP_G_THERMAL] = thermal_set_i;
   assign set_vec[`SEIP_G_BUS] = bus_set_i;
   assign set_vec[`SEIP_G_HIGHSIDE] = highside_set_i;
   assign set_vec[`SEIP_G_DRAIN_SOURCE_OVERVOLT_REG] = drain_source_overvolt_reg_set_i;
   assign set_vec[`SEIP_G_DEVICE] = device_set_i;
   assign set_vec[`SEIP_G_WAKE] = {3'h0, wake_set_i};

   // Pulsing only in normal and stop; other modes keep the pin quiet
   assign active = (mode_i == seip_pkg::SEIP_MODE_NORMAL) ||
                   (mode_i == seip_pkg::SEIP_MODE_STOP);

   always_comb begin
      for (int g = 0; g < NG; g++) begin
         if (wr_i && (addr_i == 4'(`SEIP_OFS_STAT_BASE + g))) begin
            clr_vec[g] = wdata_i;
         end else begin
            clr_vec[g] = 8'h00;
         end
         // A set in the clearing cycle survives the clear
         next_stat[g] = (stat[g] & ~clr_vec[g]) | set_vec[g];
      end
   end

   // Live latched status, cleared only by a software write of ones
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int g = 0; g < NG; g++) begin
            stat[g] <= 8'h00;
         end
      end else begin
         for (int g = 0; g < NG; g++) begin
            stat[g] <= next_stat[g];
         end
      end
   end

   // Readable copy refreshed when the pin falls; clears apply at once
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int g = 0; g < NG; g++) begin
            view[g] <= 8'h00;
         end
      end else begin
         for (int g = 0; g < NG; g++) begin
            if (start) begin
               view[g] <= next_stat[g];
            end else begin
               view[g] <= view[g] & ~clr_vec[g];
            end
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_mask <= `SEIP_RST_MASK;
         ctrl <= `SEIP_RST_CTRL;
         wake_en <= `SEIP_RST_WAKE_EN;
      end else if (wr_i) begin
         case (addr_i)
            `SEIP_OFS_MASK: begin
               int_mask <= wdata_i[5:0];
            end
            `SEIP_OFS_CTRL: begin
               ctrl <= wdata_i[1:0];
            end
            `SEIP_OFS_WAKE_EN: begin
               wake_en <= wdata_i[3:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      case (addr_i)
         `SEIP_OFS_MASK: rd_mux = {2'h0, int_mask};
         `SEIP_OFS_CTRL: rd_mux = {6'h00, ctrl};
         `SEIP_OFS_WAKE_EN: rd_mux = {4'h0, wake_en};
         `SEIP_OFS_STATE: rd_mux = {5'h00, sdm_select_o, pend,
                                    state == seip_pkg::SEIP_ST_LOW};
         default: begin
            rd_mux = 8'h00;
            for (int g = 0; g < NG; g++) begin
               if (addr_i == 4'(`SEIP_OFS_STAT_BASE + g)) begin
                  rd_mux = view[g];
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= rd_mux;
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // Group sources; excluded supply and thermal bits never count
   always_comb begin
      evt_masked =
         (int_mask[`SEIP_G_SUPPLY] &&
          grp_any(supply_set_i, `SEIP_ALLOW_SUPPLY)) ||
         (int_mask[`SEIP_G_THERMAL] &&
          grp_any(thermal_set_i, `SEIP_ALLOW_THERMAL)) ||
         (int_mask[`SEIP_G_BUS] &&
          grp_any(bus_set_i, `SEIP_ALLOW_ALL)) ||
         (int_mask[`SEIP_G_HIGHSIDE] &&
          grp_any(highside_set_i, `SEIP_ALLOW_ALL)) ||
         (int_mask[`SEIP_G_DRAIN_SOURCE_OVERVOLT_REG] &&
          grp_any(drain_source_overvolt_reg_set_i, `SEIP_ALLOW_ALL)) ||
         (int_mask[`SEIP_G_DEVICE] &&
          grp_any(device_set_i, `SEIP_ALLOW_DEVICE));
   end

   // Brake detection counts as a wake source only with braking on
   assign wake_qual = {3'h0, ctrl[`SEIP_CTRL_BRAKE], wake_en};
   assign evt_wake = grp_any(set_vec[`SEIP_G_WAKE], wake_qual);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q <= seip_pkg::SEIP_MODE_INIT;
      end else begin
         mode_q <= mode_i;
      end
   end

   assign stop_entry = (mode_i == seip_pkg::SEIP_MODE_STOP) &&
                       (mode_q != seip_pkg::SEIP_MODE_STOP) &&
                       (grp_any(stat[`SEIP_G_WAKE], `SEIP_WAKE_ALL) ||
                        grp_any(stat[`SEIP_G_DRAIN_SOURCE_OVERVOLT_REG],
                                `SEIP_DRAIN_SOURCE_OVERVOLT_REG_BRAKE));

   // Repeat period counter runs free while active; restarted per pulse
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rcnt <= '0;
      end else if (!active || start) begin
         rcnt <= '0;
      end else if (rcnt == last_of(REPEAT_CYC)) begin
         rcnt <= '0;
      end else begin
         rcnt <= rcnt + 1'b1;
      end
   end

   assign repeat_hit = (rcnt == last_of(REPEAT_CYC)) &&
                       ctrl[`SEIP_CTRL_REPEAT] &&
                       int_mask[`SEIP_G_DEVICE] &&
                       grp_any(stat[`SEIP_G_DEVICE],
                               `SEIP_ALLOW_DEVICE);

   // Both methods feed one request
   assign trig = evt_masked || evt_wake || stop_entry ||
                 repeat_hit;

   // Requests during a low phase merge into it; during the gap they wait
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend <= 1'b0;
      end else if (!active) begin
         pend <= 1'b0;
      end else if (start || state == seip_pkg::SEIP_ST_LOW) begin
         pend <= 1'b0;
      end else if (trig) begin
         pend <= 1'b1;
      end
   end

   assign start = active && pend && (state == seip_pkg::SEIP_ST_IDLE);

   assign tdone = ((state == seip_pkg::SEIP_ST_LOW) &&
                   (tcnt == last_of(PULSE_CYC))) ||
                  ((state == seip_pkg::SEIP_ST_GAP) &&
                   (tcnt == last_of(GAP_CYC)));

   always_comb begin
      next_state = state;
      case (state)
         seip_pkg::SEIP_ST_IDLE: begin
            if (start) begin
               next_state = seip_pkg::SEIP_ST_LOW;
            end
         end
         seip_pkg::SEIP_ST_LOW: begin
            if (tdone) begin
               next_state = seip_pkg::SEIP_ST_GAP;
            end
         end
         seip_pkg::SEIP_ST_GAP: begin
            if (tdone) begin
               next_state = seip_pkg::SEIP_ST_IDLE;
            end
         end
         default: begin
            next_state = seip_pkg::SEIP_ST_IDLE;
         end
      endcase
      if (!active) begin
         next_state = seip_pkg::SEIP_ST_IDLE;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= seip_pkg::SEIP_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tcnt <= '0;
      end else if (next_state != state) begin
         tcnt <= '0;
      end else if (state != seip_pkg::SEIP_ST_IDLE) begin
         tcnt <= tcnt + 1'b1;
      end
   end

   // Registered pin drive; no mode output exists, so pulses cannot
   // move the device out of its mode
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_n_o <= 1'b1;
         irq_oe_o <= 1'b0;
      end else begin
         irq_n_o <= (next_state != seip_pkg::SEIP_ST_LOW);
         irq_oe_o <= active;
      end
   end

   // Init leaves the pin undriven so its strap level can be read
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sdm_select_o <= 1'b0;
      end else if (mode_i == seip_pkg::SEIP_MODE_INIT) begin
         sdm_select_o <= irq_in_i;
      end
   end

endmodule

// ### seip_pulser_assertions.sv
`timescale 1ns/10ps
module seip_pulser_checker #(
   parameter int PULSE_CYC = 4,
   parameter int GAP_CYC = 4
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire seip_pkg::seip_mode_t mode_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic irq_in_i,
   input wire logic irq_n_o,
   input wire logic irq_oe_o,
   input wire logic sdm_select_o
);
   logic [19:0] lo_cnt;
   logic [19:0] hi_cnt;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // High time saturates at the gap so the first pulse after reset is legal
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lo_cnt <= 20'h0_0000;
         hi_cnt <= 20'(GAP_CYC);
      end else if (irq_n_o) begin
         lo_cnt <= 20'h0_0000;
         if (hi_cnt < 20'(GAP_CYC)) begin
            hi_cnt <= hi_cnt + 20'h0_0001;
         end
      end else begin
         lo_cnt <= lo_cnt + 20'h0_0001;
         hi_cnt <= 20'h0_0000;
      end
   end
   sequence s_mask_wr;
      wr_i && addr_i == 4'h0;
   endsequence
   sequence s_mask_rd;
      rd_i && addr_i == 4'h0;
   endsequence
   a_pulse_width: assert property (
      $rose(irq_n_o) |-> lo_cnt == 20'(PULSE_CYC))
      else $error("pulse width wrong");
   a_gap_min: assert property (
      $fell(irq_n_o) |-> hi_cnt >= 20'(GAP_CYC))
      else $error("gap too short");
   a_quiet_modes: assert property (
      (mode_i != seip_pkg::SEIP_MODE_NORMAL &&
       mode_i != seip_pkg::SEIP_MODE_STOP) [*2] |-> !irq_oe_o && irq_n_o)
      else $error("pin active in quiet mode");
   a_drive_normal: assert property (
      (mode_i == seip_pkg::SEIP_MODE_NORMAL) [*2] |-> irq_oe_o)
      else $error("pin not driven in normal mode");
   a_read_idle: assert property (
      !rd_i |=> rdata_o == 8'h00)
      else $error("read data outside read slot");
   // The release edge still finds the flop in reset, so skip that attempt
   a_sdm_sample: assert property (
      rst_n_i && mode_i == seip_pkg::SEIP_MODE_INIT |=>
         sdm_select_o == $past(irq_in_i))
      else $error("select not sampled in init");
   a_sdm_hold: assert property (
      mode_i != seip_pkg::SEIP_MODE_INIT |=> $stable(sdm_select_o))
      else $error("select changed outside init");
   a_mask_back: assert property (
      s_mask_wr ##1 s_mask_rd |=> rdata_o == ($past(wdata_i, 2) & 8'h3F))
      else $error("mask readback wrong");
endmodule

// ### seip_mcu_model.sv
`timescale 1ns/10ps
module seip_mcu_model (
   input wire logic mclk_i,
   input wire logic irq_n_i,
   input wire logic irq_oe_i,
   input wire logic strap_low_i,
   output logic pin_o,
   output int unsigned falls_o
);
   logic last = 1'b1;
   int unsigned cnt = 0;
   // Released pin rests on the pull-up unless the host straps it low
   assign pin_o = irq_oe_i ? irq_n_i : !strap_low_i;
   assign falls_o = cnt;
   always @(posedge mclk_i) begin
      last <= pin_o;
      if (last && !pin_o) begin
         cnt <= cnt + 1;
      end
   end
endmodule

// ### status_event_interrupt_pulser_tb_top.sv
`timescale 1ns/10ps
module status_event_interrupt_pulser_tb_top;
   logic mclk_i;
   logic rst_n_i;
   seip_pkg::seip_mode_t mode;
   logic [7:0] sets [0:6];
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr_s;
   logic rd_s;
   logic [7:0] rdata;
   logic pin;
   logic irq_n;
   logic irq_oe;
   logic sdm;
   logic strap_low;
   int unsigned falls;
   int err_total = 0;
   int n_checks = 0;
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   seip_pulser #(.PULSE_CYC(4), .GAP_CYC(4), .REPEAT_CYC(40)) u_seip_pulser (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .mode_i(mode),
      .supply_set_i(sets[0]), .thermal_set_i(sets[1]), .bus_set_i(sets[2]),
      .highside_set_i(sets[3]), .drain_source_overvolt_reg_set_i(sets[4]),
      .device_set_i(sets[5]), .wake_set_i(sets[6][4:0]),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
      .rdata_o(rdata), .irq_in_i(pin), .irq_n_o(irq_n), .irq_oe_o(irq_oe),
      .sdm_select_o(sdm));
   seip_mcu_model u_seip_mcu_model (.mclk_i(mclk_i), .irq_n_i(irq_n),
      .irq_oe_i(irq_oe), .strap_low_i(strap_low), .pin_o(pin),
      .falls_o(falls));
   task automatic close_out();
      if (err_total == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge mclk_i);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge mclk_i);
      wr_s <= 1'b0;
      @(posedge mclk_i);
   endtask
   // Write then read back with no gap between the strobes
   task automatic wr_rd(input logic [3:0] a, input logic [7:0] d,
                        input logic [7:0] e);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge mclk_i);
      wr_s <= 1'b0;
      rd_s <= 1'b1;
      @(posedge mclk_i);
      rd_s <= 1'b0;
      #1;
      chk("rdata", {24'h00_0000, e}, {24'h00_0000, rdata});
      @(posedge mclk_i);
   endtask
   task automatic rdv(input logic [3:0] a, input logic [7:0] e);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge mclk_i);
      rd_s <= 1'b0;
      #1;
      chk("rdata", {24'h00_0000, e}, {24'h00_0000, rdata});
      @(posedge mclk_i);
   endtask
   task automatic fire(input int g, input logic [7:0] v);
      sets[g] <= v;
      @(posedge mclk_i);
      sets[g] <= 8'h00;
      @(posedge mclk_i);
   endtask
   // Quiet window long enough for any pulse to start and finish
   task automatic none_since(input int unsigned b);
      idle(30);
      chk("pulses", b, falls);
   endtask
   task automatic got_pulse(input int unsigned b);
      for (int i = 0; i < 50 && falls == b; i++) @(posedge mclk_i);
      chk("pulse", 1, falls != b);
      if (falls == b) close_out();
      idle(12);
   endtask
   initial begin
      int unsigned b;
      rst_n_i = 1'b0;
      mode = seip_pkg::SEIP_MODE_INIT;
      foreach (sets[i]) sets[i] = 8'h00;
      addr = 4'h0;
      wdata = 8'h00;
      wr_s = 1'b0;
      rd_s = 1'b0;
      strap_low = 1'b0;
      idle(4);
      rst_n_i <= 1'b1;
      idle(3);
      chk("sdm", 1, sdm);
      rdv(4'h0, 8'h3F);
      rdv(4'h1, 8'h01);
      rdv(4'h2, 8'h0F);
      rdv(4'hF, 8'h00);
      mode <= seip_pkg::SEIP_MODE_NORMAL;
      idle(3);
      b = falls;
      fire(2, 8'h01);
      got_pulse(b);
      rdv(4'h5, 8'h01);
      rdv(4'h5, 8'h01);
      wr(4'h5, 8'hFF);
      rdv(4'h5, 8'h00);
      b = falls;
      fire(0, 8'h0F);
      fire(1, 8'h80);
      fire(5, 8'h04);
      none_since(b);
      wr(4'h3, 8'hFF);
      wr(4'h4, 8'hFF);
      wr(4'h8, 8'hFF);
      wr_rd(4'h0, 8'h3B, 8'h3B);
      fire(2, 8'h01);
      none_since(b);
      wr(4'h5, 8'hFF);
      wr_rd(4'h0, 8'hFF, 8'h3F);
      sets[2] <= 8'h02;
      sets[3] <= 8'h10;
      fire(6, 8'h01);
      sets[2] <= 8'h00;
      sets[3] <= 8'h00;
      idle(30);
      chk("pulses", b + 1, falls);
      for (int a = 5; a < 10; a++) wr(a[3:0], 8'hFF);
      b = falls;
      wr(4'h2, 8'h0D);
      fire(6, 8'h12);
      none_since(b);
      wr(4'h9, 8'hFF);
      wr(4'h2, 8'h0F);
      wr(4'h1, 8'h03);
      fire(6, 8'h10);
      got_pulse(b);
      wr(4'h9, 8'hFF);
      b = falls;
      fire(5, 8'h01);
      idle(40);
      chk("pulses", b + 1, falls);
      idle(60);
      chk("pulses", b + 3, falls);
      wr(4'h1, 8'h00);
      b = falls;
      idle(100);
      chk("pulses", b, falls);
      wr(4'h8, 8'hFF);
      wr(4'h1, 8'h01);
      b = falls;
      fire(2, 8'h01);
      idle(100);
      chk("pulses", b + 1, falls);
      wr(4'h5, 8'hFF);
      mode <= seip_pkg::SEIP_MODE_SLEEP;
      idle(3);
      chk("oe", 0, irq_oe);
      b = falls;
      fire(6, 8'h02);
      none_since(b);
      mode <= seip_pkg::SEIP_MODE_STOP;
      got_pulse(b);
      chk("oe_kept", 1, irq_oe);
      rdv(4'hA, 8'h04);
      b = falls;
      mode <= seip_pkg::SEIP_MODE_RESTART;
      fire(2, 8'h01);
      mode <= seip_pkg::SEIP_MODE_FAILSAFE;
      none_since(b);
      chk("oe", 0, irq_oe);
      wr(4'h0, 8'h00);
      rst_n_i <= 1'b0;
      idle(4);
      rst_n_i <= 1'b1;
      idle(2);
      chk("sdm", 0, sdm);
      rdv(4'h0, 8'h3F);
      close_out();
   end
endmodule
bind seip_pulser seip_pulser_checker #(.PULSE_CYC(PULSE_CYC),
   .GAP_CYC(GAP_CYC)) u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
   .mode_i(mode_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .irq_in_i(irq_in_i),
   .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o), .sdm_select_o(sdm_select_o));
